// [hdl/cbf_exec_unit.sv]
// execution unit for stores, program loads, stack, I/O bit and flag instructions
`timescale 1ns/1ps
`include "cbf_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - pre-decrement pointer, then store; two cycles
// - store at pointer plus displacement, two cycles
// - store at direct address, two cycles
// - program load into register, optional increment, three cycles
// - push register to stack, two cycles
// - pop stack byte into register, two cycles
// - set one I/O bit, two cycles
// - clear one I/O bit, two cycles
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - dedicated flag set and clear, one cycle
// - indexed status bit set or clear
// - sleep takes one cycle, flags kept
// - watchdog restart takes one cycle, flags kept
module cbf_exec_unit (
   // clock and reset
   input logic clk_in,
   input logic rst_in,
   // instruction handoff
   input logic op_valid_in,
   input cbf_pkg::cbf_op_t op_code_in,
   input logic [4:0] reg_sel_in,
   input logic [2:0] bit_sel_in,
   input logic [5:0] disp_in,
   input logic [15:0] direct_addr_in,
   input logic [5:0] io_addr_in,
   output logic ready_out,
   output logic done_out,
   // status
   output logic [7:0] status_flags_out,
   output logic [15:0] stack_ptr_out,
   output logic sleep_req_out,
   output logic wdt_restart_out,
   // data memory
   output logic [15:0] dmem_addr_out,
   output logic [7:0] dmem_wdata_out,
   output logic dmem_we_out,
   output logic dmem_re_out,
   input logic [7:0] dmem_rdata_in,
   // program memory
   output logic [15:0] pmem_addr_out,
   output logic pmem_re_out,
   input logic [7:0] pmem_rdata_in,
   // I/O registers
   output logic [5:0] io_addr_out,
   output logic io_re_out,
   output logic io_we_out,
   output logic [7:0] io_wdata_out,
   input logic [7:0] io_rdata_in
);

   cbf_pkg::cbf_state_t state;
   cbf_pkg::cbf_state_t next_state;
   cbf_pkg::cbf_op_t op_q;
   logic [4:0] reg_q;
   logic [2:0] bit_q;
   logic [5:0] disp_q;
   logic [15:0] addr_q;
   logic accept;
   logic [7:0] rd_data;
   logic [15:0] z_data;
   logic [4:0] rd_addr;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic z_we;
   logic [15:0] z_wdata;
   logic [7:0] sh_result;
   logic sh_c;
   logic sh_z;
   logic sh_n;
   logic sh_v;
   logic [7:0] op_mask;
   logic in_exec;

   assign accept = op_valid_in && ready_out;
   assign in_exec = (state == cbf_pkg::CBF_EXEC);
   assign op_mask = cbf_pkg::cbf_bit_mask(bit_q);
   // read port follows the new operand on accept, then holds it
   assign rd_addr = accept ? reg_sel_in : reg_q;

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_comb
   begin
      next_state = state;
      unique case (state)
         cbf_pkg::CBF_IDLE:
            next_state = accept ? cbf_pkg::CBF_EXEC : cbf_pkg::CBF_IDLE;
         cbf_pkg::CBF_EXEC:
         begin
            if (cbf_pkg::cbf_is_pm_load(op_q))
               next_state = cbf_pkg::CBF_WAIT;
            else if (cbf_pkg::cbf_two_cycle(op_q))
               next_state = cbf_pkg::CBF_MEM;
            else
               next_state = cbf_pkg::CBF_IDLE;
         end
         cbf_pkg::CBF_WAIT:
            next_state = cbf_pkg::CBF_MEM;
         cbf_pkg::CBF_MEM:
            next_state = cbf_pkg::CBF_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state <= cbf_pkg::CBF_IDLE;
         ready_out <= 1'b1;
         done_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ready_out <= (next_state == cbf_pkg::CBF_IDLE);
         done_out <= (state != cbf_pkg::CBF_IDLE) && (next_state == cbf_pkg::CBF_IDLE);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         op_q <= cbf_pkg::no_op;
         reg_q <= `CBF_REG_R0;
         bit_q <= 3'h0;
         disp_q <= 6'h00;
         addr_q <= 16'h0000;
      end
      else if (accept)
      begin
         op_q <= op_code_in;
         // the operand-less program load always targets register zero
         reg_q <= (op_code_in == cbf_pkg::program_memory_load_op) ? `CBF_REG_R0 : reg_sel_in;
         bit_q <= bit_sel_in;
         disp_q <= disp_in;
         addr_q <= direct_addr_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // datapath

   cbf_reg_file u_regs (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .rd_addr_in(rd_addr),
      .rd_data_out(rd_data),
      .ptr_data_out(z_data),
      .wr_en_in(wr_en),
      .wr_addr_in(wr_addr),
      .wr_data_in(wr_data),
      .ptr_we_in(z_we),
      .ptr_wdata_in(z_wdata)
   );

   cbf_shift_unit u_shift (
      .op_in(op_q),
      .value_in(rd_data),
      .bit_sel_in(bit_q),
      .carry_in(status_flags_out[`CBF_FLAG_C]),
      .t_flag_in(status_flags_out[`CBF_FLAG_T]),
      .result_out(sh_result),
      .carry_out(sh_c),
      .zero_out(sh_z),
      .neg_out(sh_n),
      .ovf_out(sh_v)
   );

   always_comb
   begin
      wr_en = 1'b0;
      wr_addr = reg_q;
      wr_data = sh_result;
      z_we = 1'b0;
      z_wdata = z_data;
      if (in_exec && (cbf_pkg::cbf_is_shift(op_q) || op_q == cbf_pkg::nibble_swap_op ||
         op_q == cbf_pkg::flag_to_register_bit_op))
         wr_en = 1'b1;
      if (state == cbf_pkg::CBF_MEM && op_q == cbf_pkg::pop_op)
      begin
         wr_en = 1'b1;
         wr_data = dmem_rdata_in;
      end
      if (state == cbf_pkg::CBF_MEM && cbf_pkg::cbf_is_pm_load(op_q))
      begin
         wr_en = 1'b1;
         wr_data = pmem_rdata_in;
      end
      if (in_exec && op_q == cbf_pkg::indirect_store_op)
      begin
         z_we = 1'b1;
         z_wdata = z_data - 16'h0001;
      end
      if (in_exec && op_q == cbf_pkg::program_memory_load_inc_op)
      begin
         z_we = 1'b1;
         z_wdata = z_data + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data memory and stack

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dmem_addr_out <= 16'h0000;
         dmem_wdata_out <= 8'h00;
         dmem_we_out <= 1'b0;
         dmem_re_out <= 1'b0;
      end
      else
      begin
         dmem_we_out <= 1'b0;
         dmem_re_out <= 1'b0;
         if (in_exec)
         begin
            dmem_wdata_out <= rd_data;
            unique case (op_q)
               cbf_pkg::indirect_store_op:
               begin
                  dmem_addr_out <= z_data - 16'h0001;
                  dmem_we_out <= 1'b1;
               end
               cbf_pkg::displacement_store_op:
               begin
                  dmem_addr_out <= z_data + {10'h000, disp_q};
                  dmem_we_out <= 1'b1;
               end
               cbf_pkg::direct_store_op:
               begin
                  dmem_addr_out <= addr_q;
                  dmem_we_out <= 1'b1;
               end
               cbf_pkg::push_op:
               begin
                  dmem_addr_out <= stack_ptr_out;
                  dmem_we_out <= 1'b1;
               end
               cbf_pkg::pop_op:
               begin
                  dmem_addr_out <= stack_ptr_out + 16'h0001;
                  dmem_re_out <= 1'b1;
               end
               default:
                  dmem_addr_out <= dmem_addr_out;
            endcase
         end
      end
   end

   // stack grows downward: push post-decrements, pop pre-increments
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         stack_ptr_out <= `CBF_SP_RESET;
      else if (in_exec && op_q == cbf_pkg::push_op)
         stack_ptr_out <= stack_ptr_out - 16'h0001;
      else if (in_exec && op_q == cbf_pkg::pop_op)
         stack_ptr_out <= stack_ptr_out + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // program memory and I/O bit access

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pmem_addr_out <= 16'h0000;
         pmem_re_out <= 1'b0;
      end
      else
      begin
         pmem_re_out <= in_exec && cbf_pkg::cbf_is_pm_load(op_q);
         if (in_exec && cbf_pkg::cbf_is_pm_load(op_q))
            pmem_addr_out <= z_data;
      end
   end

   // read is issued on accept so the modify-write fits in two cycles
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         io_addr_out <= 6'h00;
         io_re_out <= 1'b0;
         io_we_out <= 1'b0;
         io_wdata_out <= 8'h00;
      end
      else
      begin
         io_re_out <= accept && (op_code_in == cbf_pkg::io_bit_set_op ||
            op_code_in == cbf_pkg::io_bit_clear_op);
         io_we_out <= in_exec && (op_q == cbf_pkg::io_bit_set_op ||
            op_q == cbf_pkg::io_bit_clear_op);
         if (accept)
            io_addr_out <= io_addr_in;
         if (in_exec && op_q == cbf_pkg::io_bit_set_op)
            io_wdata_out <= io_rdata_in | op_mask;
         else if (in_exec && op_q == cbf_pkg::io_bit_clear_op)
            io_wdata_out <= io_rdata_in & ~op_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status flags and system requests

   // single-flag set and clear forms arrive as the indexed set and clear
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         status_flags_out <= `CBF_FLAGS_RESET;
      else if (in_exec)
      begin
         if (cbf_pkg::cbf_is_shift(op_q))
         begin
            status_flags_out[`CBF_FLAG_C] <= sh_c;
            status_flags_out[`CBF_FLAG_Z] <= sh_z;
            status_flags_out[`CBF_FLAG_N] <= sh_n;
            status_flags_out[`CBF_FLAG_V] <= sh_v;
         end
         else if (op_q == cbf_pkg::register_bit_to_flag_op)
            status_flags_out[`CBF_FLAG_T] <= rd_data[bit_q];
         else if (op_q == cbf_pkg::generic_flag_set_op)
            status_flags_out <= status_flags_out | op_mask;
         else if (op_q == cbf_pkg::generic_flag_clear_op)
            status_flags_out <= status_flags_out & ~op_mask;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sleep_req_out <= 1'b0;
         wdt_restart_out <= 1'b0;
      end
      else
      begin
         sleep_req_out <= in_exec && op_q == cbf_pkg::sleep_op;
         wdt_restart_out <= in_exec && op_q == cbf_pkg::watchdog_restart_op;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   a_predec_store: assert property (@(posedge clk_in) disable iff (rst_in)
      in_exec && op_q == cbf_pkg::indirect_store_op |=>
      dmem_we_out && dmem_addr_out == $past(z_data) - 16'h0001 ##1 z_data == dmem_addr_out)
      else $error("pre-decrement store address or pointer wrong");

   a_disp_store: assert property (@(posedge clk_in) disable iff (rst_in)
      in_exec && op_q == cbf_pkg::displacement_store_op |=>
      dmem_we_out && dmem_addr_out == $past(z_data) + {10'h000, $past(disp_q)})
      else $error("displacement store address wrong");

   a_store_timing: assert property (@(posedge clk_in) disable iff (rst_in)
      accept && op_code_in == cbf_pkg::direct_store_op |->
      ##1 $stable(status_flags_out) ##1 dmem_we_out && $stable(status_flags_out)
      ##1 !dmem_we_out && ready_out)
      else $error("direct store not two cycles");

   a_pm_load_time: assert property (@(posedge clk_in) disable iff (rst_in)
      accept && cbf_pkg::cbf_is_pm_load(op_code_in) |->
      ##1 !ready_out [*3] ##1 ready_out && done_out)
      else $error("program load not three cycles");

   a_pop_sp: assert property (@(posedge clk_in) disable iff (rst_in)
      accept && op_code_in == cbf_pkg::pop_op |->
      ##2 dmem_re_out && dmem_addr_out == stack_ptr_out)
      else $error("pop address does not follow stack pointer");

   a_io_set: assert property (@(posedge clk_in) disable iff (rst_in)
      in_exec && op_q == cbf_pkg::io_bit_set_op |=>
      io_we_out && io_wdata_out == ($past(io_rdata_in) | $past(op_mask)))
      else $error("io bit set value wrong");

   a_rotate_carry: assert property (@(posedge clk_in) disable iff (rst_in)
      in_exec && op_q == cbf_pkg::rotate_left_through_carry |=>
      status_flags_out[`CBF_FLAG_C] == $past(rd_data[7]))
      else $error("rotate left carry wrong");

   a_flag_bit_set: assert property (@(posedge clk_in) disable iff (rst_in)
      in_exec && op_q == cbf_pkg::generic_flag_set_op |=>
      status_flags_out == ($past(status_flags_out) | $past(op_mask)))
      else $error("indexed flag set wrong");

   a_sleep_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      accept && op_code_in == cbf_pkg::sleep_op |->
      ##2 sleep_req_out && ready_out && $stable(status_flags_out) ##1 !sleep_req_out)
      else $error("sleep request not a single pulse");

endmodule

// [hdl/cbf_pkg.sv]
// types and decode helpers for the store, bit and flag execution unit
package cbf_pkg;

   typedef enum logic [4:0] {
      no_op = 5'h00,
      indirect_store_op = 5'h01,
      displacement_store_op = 5'h02,
      direct_store_op = 5'h03,
      program_memory_load_op = 5'h04,
      program_memory_load_reg_op = 5'h05,
      program_memory_load_inc_op = 5'h06,
      push_op = 5'h07,
      pop_op = 5'h08,
      io_bit_set_op = 5'h09,
      io_bit_clear_op = 5'h0A,
      shift_left_op = 5'h0B,
      shift_right_op = 5'h0C,
      rotate_left_through_carry = 5'h0D,
      rotate_right_through_carry = 5'h0E,
      arith_shift_right_op = 5'h0F,
      nibble_swap_op = 5'h10,
      generic_flag_set_op = 5'h11,
      generic_flag_clear_op = 5'h12,
      register_bit_to_flag_op = 5'h13,
      flag_to_register_bit_op = 5'h14,
      sleep_op = 5'h15,
      watchdog_restart_op = 5'h16
   } cbf_op_t;

   typedef enum logic [1:0] {
      CBF_IDLE = 2'h0,
      CBF_EXEC = 2'h1,
      CBF_MEM = 2'h2,
      CBF_WAIT = 2'h3
   } cbf_state_t;

   function automatic logic [7:0] cbf_bit_mask(input logic [2:0] idx);
      cbf_bit_mask = 8'h01 << idx;
   endfunction

   function automatic logic cbf_two_cycle(input cbf_op_t op);
      cbf_two_cycle = (op == indirect_store_op) || (op == displacement_store_op) ||
         (op == direct_store_op) || (op == push_op) || (op == pop_op) ||
         (op == io_bit_set_op) || (op == io_bit_clear_op);
   endfunction

   function automatic logic cbf_is_pm_load(input cbf_op_t op);
      cbf_is_pm_load = (op == program_memory_load_op) ||
         (op == program_memory_load_reg_op) || (op == program_memory_load_inc_op);
   endfunction

   function automatic logic cbf_is_shift(input cbf_op_t op);
      cbf_is_shift = (op == shift_left_op) || (op == shift_right_op) ||
         (op == rotate_left_through_carry) || (op == rotate_right_through_carry) ||
         (op == arith_shift_right_op);
   endfunction

endpackage

// [hdl/cbf_reg_file.sv]
// working register file, 32 x 8, registered reads plus pointer pair
`timescale 1ns/1ps
`include "cbf_regs.svh"

module cbf_reg_file (
   // clock and reset
   input logic clk_in,
   input logic rst_in,
   // operand read
   input logic [4:0] rd_addr_in,
   output logic [7:0] rd_data_out,
   output logic [15:0] ptr_data_out,
   // byte write
   input logic wr_en_in,
   input logic [4:0] wr_addr_in,
   input logic [7:0] wr_data_in,
   // pointer pair write
   input logic ptr_we_in,
   input logic [15:0] ptr_wdata_in
);

   logic [7:0] mem [0:31];

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_word
         // byte port wins over the pointer port on a clash
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
               mem[gi] <= `CBF_GPR_RESET;
            else if (wr_en_in && wr_addr_in == 5'(gi))
               mem[gi] <= wr_data_in;
            else if (ptr_we_in && 5'(gi) == `CBF_PTR_LO)
               mem[gi] <= ptr_wdata_in[7:0];
            else if (ptr_we_in && 5'(gi) == `CBF_PTR_HI)
               mem[gi] <= ptr_wdata_in[15:8];
         end
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_data_out <= `CBF_GPR_RESET;
         ptr_data_out <= {`CBF_GPR_RESET, `CBF_GPR_RESET};
      end
      else
      begin
         rd_data_out <= mem[rd_addr_in];
         ptr_data_out <= {mem[`CBF_PTR_HI], mem[`CBF_PTR_LO]};
      end
   end

endmodule

// [hdl/cbf_regs.svh]
// constants for the store, bit and flag execution unit
`ifndef CBF_REGS_SVH
`define CBF_REGS_SVH

// status flag bit positions
`define CBF_FLAG_C 3'h0
`define CBF_FLAG_Z 3'h1
`define CBF_FLAG_N 3'h2
`define CBF_FLAG_V 3'h3
`define CBF_FLAG_S 3'h4
`define CBF_FLAG_H 3'h5
`define CBF_FLAG_T 3'h6
`define CBF_FLAG_I 3'h7

// reset values
`define CBF_FLAGS_RESET 8'h00
`define CBF_GPR_RESET 8'h00
`define CBF_SP_RESET 16'hFFFF

// fixed register indices
`define CBF_REG_R0 5'h00
`define CBF_PTR_LO 5'h1E
`define CBF_PTR_HI 5'h1F

`endif

// [hdl/cbf_shift_unit.sv]
// shift, rotate, swap and bit-load datapath with flag results
`timescale 1ns/1ps

module cbf_shift_unit (
   // operation
   input cbf_pkg::cbf_op_t op_in,
   input logic [7:0] value_in,
   input logic [2:0] bit_sel_in,
   input logic carry_in,
   input logic t_flag_in,
   // results
   output logic [7:0] result_out,
   output logic carry_out,
   output logic zero_out,
   output logic neg_out,
   output logic ovf_out
);

   logic [7:0] mask;

   always_comb
   begin
      mask = cbf_pkg::cbf_bit_mask(bit_sel_in);
      result_out = value_in;
      carry_out = carry_in;
      unique case (op_in)
         cbf_pkg::shift_left_op:
         begin
            result_out = {value_in[6:0], 1'b0};
            carry_out = value_in[7];
         end
         cbf_pkg::shift_right_op:
         begin
            result_out = {1'b0, value_in[7:1]};
            carry_out = value_in[0];
         end
         cbf_pkg::rotate_left_through_carry:
         begin
            result_out = {value_in[6:0], carry_in};
            carry_out = value_in[7];
         end
         cbf_pkg::rotate_right_through_carry:
         begin
            result_out = {carry_in, value_in[7:1]};
            carry_out = value_in[0];
         end
         cbf_pkg::arith_shift_right_op:
         begin
            result_out = {value_in[7], value_in[7:1]};
            carry_out = value_in[0];
         end
         cbf_pkg::nibble_swap_op:
            result_out = {value_in[3:0], value_in[7:4]};
         cbf_pkg::flag_to_register_bit_op:
            result_out = t_flag_in ? (value_in | mask) : (value_in & ~mask);
         default:
            result_out = value_in;
      endcase
      zero_out = (result_out == 8'h00);
      neg_out = result_out[7];
      // overflow after a shift is sign xor carry
      ovf_out = result_out[7] ^ carry_out;
   end

endmodule

// [testbench/cbf_mem_model.sv]
// data, program and I/O memory model facing the execution unit
`timescale 1ns/1ps

module cbf_mem_model (
   // clock
   input logic clk_in,
   // data memory
   input logic [15:0] dmem_addr_in,
   input logic [7:0] dmem_wdata_in,
   input logic dmem_we_in,
   input logic dmem_re_in,
   output logic [7:0] dmem_rdata_out,
   // program memory
   input logic [15:0] pmem_addr_in,
   input logic pmem_re_in,
   output logic [7:0] pmem_rdata_out,
   // I/O registers
   input logic [5:0] io_addr_in,
   input logic io_we_in,
   input logic [7:0] io_wdata_in,
   input logic io_re_in,
   output logic [7:0] io_rdata_out
);
   logic [7:0] dmem [256];
   logic [7:0] pmem [256];
   logic [7:0] io [64];
   logic [7:0] junk = 8'h5A;
   logic [7:0] pdata = 8'h00;
   logic pvalid = 1'b0;
   // outside a read the buses churn, so a late or early sample shows up
   assign dmem_rdata_out = dmem_re_in ? dmem[dmem_addr_in[7:0]] : junk;
   assign io_rdata_out = io_re_in ? io[io_addr_in] : ~junk;
   assign pmem_rdata_out = pvalid ? pdata : junk;
   always @(posedge clk_in)
   begin
      junk <= ~junk + 8'h01;
      pvalid <= pmem_re_in;
      if (pmem_re_in) pdata <= pmem[pmem_addr_in[7:0]];
      if (dmem_we_in) dmem[dmem_addr_in[7:0]] <= dmem_wdata_in;
      if (io_we_in) io[io_addr_in] <= io_wdata_in;
   end
endmodule

// [testbench/test_cbf_exec_unit.sv]
// self-checking bench for the store, bit and flag execution unit
`timescale 1ns/1ps

module test_cbf_exec_unit;
   typedef struct {
      cbf_pkg::cbf_op_t op;
      logic [2:0] b;
      logic [7:0] flags;
   } cbf_row_t;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic op_valid_in = 1'b0;
   cbf_pkg::cbf_op_t op_code_in = cbf_pkg::no_op;
   logic [4:0] reg_sel_in = 5'h00;
   logic [2:0] bit_sel_in = 3'h0;
   logic [5:0] disp_in = 6'h00;
   logic [15:0] direct_addr_in = 16'h0000;
   logic [5:0] io_addr_in = 6'h00;
   logic ready_out, done_out, sleep_req_out, wdt_restart_out;
   logic [7:0] status_flags_out, dmem_wdata_out, dmem_rdata_in, pmem_rdata_in;
   logic [15:0] stack_ptr_out, dmem_addr_out, pmem_addr_out;
   logic dmem_we_out, dmem_re_out, pmem_re_out, io_re_out, io_we_out;
   logic [5:0] io_addr_out;
   logic [7:0] io_wdata_out, io_rdata_in;
   logic [1:0] pulse;
   cbf_row_t rows [18];
   int num_errors = 0;
   int n_compared = 0;

   cbf_exec_unit DUT (.clk_in, .rst_in, .op_valid_in, .op_code_in, .reg_sel_in,
      .bit_sel_in, .disp_in, .direct_addr_in, .io_addr_in, .ready_out, .done_out,
      .status_flags_out, .stack_ptr_out, .sleep_req_out, .wdt_restart_out,
      .dmem_addr_out, .dmem_wdata_out, .dmem_we_out, .dmem_re_out, .dmem_rdata_in,
      .pmem_addr_out, .pmem_re_out, .pmem_rdata_in, .io_addr_out, .io_re_out,
      .io_we_out, .io_wdata_out, .io_rdata_in);

   cbf_mem_model MEM (.clk_in(clk_in), .dmem_addr_in(dmem_addr_out),
      .dmem_wdata_in(dmem_wdata_out), .dmem_we_in(dmem_we_out),
      .dmem_re_in(dmem_re_out), .dmem_rdata_out(dmem_rdata_in),
      .pmem_addr_in(pmem_addr_out), .pmem_re_in(pmem_re_out),
      .pmem_rdata_out(pmem_rdata_in), .io_addr_in(io_addr_out), .io_we_in(io_we_out),
      .io_wdata_in(io_wdata_out), .io_re_in(io_re_out), .io_rdata_out(io_rdata_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      n_compared++;
      if (got != exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t cycles got=%h exp=%h", $time, got, exp);
      end
   endtask

   // entered at a falling edge with ready high; leaves in the done cycle
   task automatic run(input cbf_pkg::cbf_op_t op, input logic [4:0] r,
      input logic [2:0] b, input logic [15:0] a, input int cyc);
      int n;
      op_code_in = op;
      reg_sel_in = r;
      bit_sel_in = b;
      disp_in = a[5:0];
      direct_addr_in = a;
      io_addr_in = a[5:0];
      op_valid_in = 1'b1;
      @(negedge clk_in);
      op_valid_in = 1'b0;
      n = 0;
      do
      begin
         @(negedge clk_in);
         n++;
      end
      while (done_out !== 1'b1 && n < 9);
      chk_cyc(n, cyc);
      pulse = {sleep_req_out, wdt_restart_out};
   endtask

   // registers are only visible through a store to data memory; this task uses a direct store
   task automatic st(input logic [4:0] r, input logic [7:0] a, input logic [7:0] exp);
      run(cbf_pkg::direct_store_op, r, 3'h0, {8'h00, a}, 2);
      chk_val({8'h00, MEM.dmem[a]}, {8'h00, exp});
   endtask

   task automatic end_sim;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2 clk_in = ~clk_in;
   end

   initial
   begin
      #20000;
      num_errors++;
      end_sim();
   end

   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         rows[i] = '{cbf_pkg::generic_flag_set_op, i[2:0], 8'hFF >> (7 - i)};
         rows[i + 8] = '{cbf_pkg::generic_flag_clear_op, i[2:0], 8'hFE << i};
      end
      rows[16] = '{cbf_pkg::sleep_op, 3'h0, 8'h00};
      rows[17] = '{cbf_pkg::watchdog_restart_op, 3'h0, 8'h00};
      MEM.dmem[0] = 8'h96;
      MEM.dmem[1] = 8'h10;
      MEM.dmem[2] = 8'h00;
      MEM.pmem[8'h0F] = 8'hC3;
      MEM.pmem[8'h10] = 8'h5A;
      MEM.io[5] = 8'hF0;
      repeat (12) @(negedge clk_in);
      chk_val({15'h0000, ready_out}, 16'h0001);
      chk_val({8'h00, status_flags_out}, 16'h0000);
      chk_val(stack_ptr_out, 16'hFFFF);
      rst_in = 1'b0;
      @(negedge clk_in);
      for (int r = 0; r < 18; r++)
      begin
         run(rows[r].op, 5'h00, rows[r].b, 16'h0000, 1);
         chk_val({8'h00, status_flags_out}, {8'h00, rows[r].flags});
         chk_val({14'h0000, pulse}, {14'h0000, r == 16, r == 17});
      end
      run(cbf_pkg::pop_op, 5'h05, 3'h0, 16'h0000, 2);
      chk_val(stack_ptr_out, 16'h0000);
      run(cbf_pkg::generic_flag_set_op, 5'h00, 3'h0, 16'h0000, 1);
      run(cbf_pkg::rotate_left_through_carry, 5'h05, 3'h0, 16'h0000, 1);
      chk_val({8'h00, status_flags_out}, 16'h0009);
      st(5'h05, 8'h40, 8'h2D);
      run(cbf_pkg::rotate_right_through_carry, 5'h05, 3'h0, 16'h0000, 1);
      chk_val({8'h00, status_flags_out}, 16'h0005);
      st(5'h05, 8'h41, 8'h96);
      run(cbf_pkg::register_bit_to_flag_op, 5'h05, 3'h1, 16'h0000, 1);
      chk_val({8'h00, status_flags_out}, 16'h0045);
      run(cbf_pkg::flag_to_register_bit_op, 5'h05, 3'h0, 16'h0000, 1);
      st(5'h05, 8'h42, 8'h97);
      run(cbf_pkg::pop_op, 5'h1E, 3'h0, 16'h0000, 2);
      run(cbf_pkg::pop_op, 5'h1F, 3'h0, 16'h0000, 2);
      run(cbf_pkg::indirect_store_op, 5'h05, 3'h0, 16'h0000, 2);
      chk_val({8'h00, MEM.dmem[8'h0F]}, 16'h0097);
      run(cbf_pkg::displacement_store_op, 5'h05, 3'h0, 16'h003F, 2);
      chk_val({8'h00, MEM.dmem[8'h4E]}, 16'h0097);
      run(cbf_pkg::program_memory_load_op, 5'h09, 3'h0, 16'h0000, 3);
      run(cbf_pkg::program_memory_load_inc_op, 5'h07, 3'h0, 16'h0000, 3);
      run(cbf_pkg::program_memory_load_reg_op, 5'h08, 3'h0, 16'h0000, 3);
      st(5'h00, 8'h50, 8'hC3);
      st(5'h07, 8'h51, 8'hC3);
      st(5'h08, 8'h52, 8'h5A);
      run(cbf_pkg::nibble_swap_op, 5'h08, 3'h0, 16'h0000, 1);
      st(5'h08, 8'h53, 8'hA5);
      run(cbf_pkg::push_op, 5'h08, 3'h0, 16'h0000, 2);
      chk_val(stack_ptr_out, 16'h0001);
      chk_val({8'h00, MEM.dmem[2]}, 16'h00A5);
      run(cbf_pkg::io_bit_set_op, 5'h00, 3'h0, 16'h0005, 2);
      chk_val({8'h00, MEM.io[5]}, 16'h00F1);
      run(cbf_pkg::io_bit_clear_op, 5'h00, 3'h7, 16'h0005, 2);
      chk_val({8'h00, MEM.io[5]}, 16'h0071);
      chk_val({8'h00, status_flags_out}, 16'h0045);
      // a second reset mid-run must restore the reset flags and stack pointer
      rst_in = 1'b1;
      @(negedge clk_in);
      chk_val({8'h00, status_flags_out}, 16'h0000);
      chk_val(stack_ptr_out, 16'hFFFF);
      rst_in = 1'b0;
      // first instruction, one idle cycle after the release, must be taken normally
      @(negedge clk_in);
      run(cbf_pkg::generic_flag_set_op, 5'h00, 3'h7, 16'h0000, 1);
      chk_val({8'h00, status_flags_out}, 16'h0080);
      end_sim();
   end
endmodule
